// File: adcc_top.sv
// Converter control: configuration, start/abort sequencing, SAR, results.
// Assumes an AXI4-Lite master and an analog front end with a comparator.
//
// Notes on behaviour
// - Right justify: high byte top six zero
// - Left justify: low byte bottom six zero
// - Three select bits pick conversion bit period
// - Config bits 5:4 ignore writes, read zero
// - Port field sets analog pins and references
// - Reset forces all shared pins analog
// - Clearing go aborts conversion at once
// - Aborted conversion leaves result pair untouched
// - Abort returns to acquisition on channel
// - Setting go again starts fresh conversion
// - First segment: one instruction cycle to period
// - Completion loads ten bits into pair
// - Unused result positions load as zeros
// - Result bytes are plain storage when idle
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module adcc_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // AXI4-Lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog front end
    input  wire logic        comp_above,
    output logic [9:0]       dac_code,
    output logic             sample_en,
    output logic [2:0]       chan_sel,
    output logic [7:0]       pin_analog_en,
    output logic             vref_pos_ext,
    output logic             vref_neg_ext
);
    // Write channel holding registers
    logic        aw_full_r;       // Address held
    logic [9:0]  aw_idx_r;        // Held word index
    logic        w_full_r;        // Data held
    logic [7:0]  w_byte_r;        // Held low byte
    logic        w_strb_r;        // Low lane enabled
    logic        wr_fire;         // Write performed this cycle
    logic        wr_hit;          // Write address mapped
    logic        wr_cfg;          // Strobes per register
    logic        wr_ctrl;
    logic        wr_resh;
    logic        wr_resl;

    // Read path
    logic [9:0]  ar_idx;          // Read word index
    logic [7:0]  rd_byte;         // Selected read byte
    logic        rd_hit;          // Read address mapped

    // Software visible state
    logic [7:0]  cfg_r;           // converter_config
    logic        on_r;            // Converter enabled
    logic        go_r;            // Go/done
    logic [2:0]  chan_r;          // Channel
    logic [1:0]  divl_r;          // conv_clock_div_low
    logic [7:0]  resh_r;          // result_high_byte
    logic [7:0]  resl_r;          // result_low_byte

    // Sequencer
    adcc_pkg::adcc_state_t state_r;
    logic [7:0]  seg_cnt_r;       // Clocks spent in first segment
    logic [3:0]  bit_idx_r;       // Bit under trial
    logic [9:0]  sar_r;           // Trial word
    logic [9:0]  bit_mask;        // One-hot of trial bit
    logic [9:0]  sar_eval;        // Word after decision
    logic        tad_tick;        // Bit period tick
    logic        go_start;        // Go accepted
    logic        abort;           // Go or enable cleared
    logic        done;            // Last bit decided
    logic [7:0]  new_hi;          // Justified result
    logic [7:0]  new_lo;

    // Comparator synchroniser
    logic        cmp_s1_r;
    logic        cmp_s2_r;
    logic        cmp_s3_r;
    logic        cmp_r;           // Filtered comparator

    // Pin map decode
    logic [7:0]  map_analog;
    logic        map_vpos;
    logic        map_vneg;

    // Address decode of write
    always_comb begin
        wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
        wr_cfg  = 1'b0;
        wr_ctrl = 1'b0;
        wr_resh = 1'b0;
        wr_resl = 1'b0;
        wr_hit  = 1'b1;
        if (aw_idx_r == adcc_pkg::IDX_CFG) begin
            wr_cfg = wr_fire && w_strb_r;
        end else if (aw_idx_r == adcc_pkg::IDX_CTRL) begin
            wr_ctrl = wr_fire && w_strb_r;
        end else if (aw_idx_r == adcc_pkg::IDX_RESH) begin
            wr_resh = wr_fire && w_strb_r;
        end else if (aw_idx_r == adcc_pkg::IDX_RESL) begin
            wr_resl = wr_fire && w_strb_r;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Write address and data capture, either order
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_r     <= 1'b0;
            aw_idx_r      <= 10'h000;
            w_full_r      <= 1'b0;
            w_byte_r      <= 8'h00;
            w_strb_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r     <= 1'b1;
                aw_idx_r      <= s_axi_awaddr[11:2];
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_full_r     <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r     <= 1'b1;
                w_byte_r     <= s_axi_wdata[7:0];
                w_strb_r     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_full_r     <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= adcc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read address decode and data select
    always_comb begin
        ar_idx  = s_axi_araddr[11:2];
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        if (ar_idx == adcc_pkg::IDX_CFG) begin
            rd_byte = cfg_r & adcc_pkg::CFG_WMASK;
        end else if (ar_idx == adcc_pkg::IDX_CTRL) begin
            rd_byte = 8'h00;
            rd_byte[adcc_pkg::CTRL_ON_BIT] = on_r;
            rd_byte[adcc_pkg::CTRL_GO_BIT] = go_r;
            rd_byte[adcc_pkg::CTRL_CHAN_LSB +: 3] = chan_r;
            rd_byte[adcc_pkg::CTRL_DIVL_LSB +: 2] = divl_r;
        end else if (ar_idx == adcc_pkg::IDX_RESH) begin
            rd_byte = resh_r;
        end else if (ar_idx == adcc_pkg::IDX_RESL) begin
            rd_byte = resl_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read channel: one answer per address
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= adcc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_hit ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Configuration register, unimplemented bits dropped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= adcc_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= w_byte_r & adcc_pkg::CFG_WMASK;
        end
    end

    // Control fields other than go
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            on_r   <= 1'b0;
            chan_r <= 3'h0;
            divl_r <= 2'h0;
        end else if (wr_ctrl) begin
            on_r   <= w_byte_r[adcc_pkg::CTRL_ON_BIT];
            chan_r <= w_byte_r[adcc_pkg::CTRL_CHAN_LSB +: 3];
            divl_r <= w_byte_r[adcc_pkg::CTRL_DIVL_LSB +: 2];
        end
    end

    // Go only while already acquiring, not in the enabling write
    assign go_start = wr_ctrl && (state_r == adcc_pkg::ST_ACQ) && on_r
                      && w_byte_r[adcc_pkg::CTRL_GO_BIT]
                      && w_byte_r[adcc_pkg::CTRL_ON_BIT];
    // Clearing go or enable mid conversion
    assign abort = wr_ctrl && (state_r == adcc_pkg::ST_SEG1 || state_r == adcc_pkg::ST_CONV)
                   && (!w_byte_r[adcc_pkg::CTRL_GO_BIT]
                       || !w_byte_r[adcc_pkg::CTRL_ON_BIT]);

    // Trial bit decision
    always_comb begin
        bit_mask = 10'h001 << bit_idx_r;
        sar_eval = cmp_r ? sar_r : (sar_r & ~bit_mask);
    end
    assign done = (state_r == adcc_pkg::ST_CONV) && tad_tick
                  && (bit_idx_r == 4'h0) && !abort;

    // Bit period source, restarted at go
    adcc_tad_div u_tad_div (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .restart (go_start),
        .sel     ({cfg_r[adcc_pkg::CFG_DIVH_BIT], divl_r}),
        .tick    (tad_tick)
    );

    // Last clock count of the minimum first segment
    localparam logic [7:0] TCY_LAST = adcc_pkg::TCY_CYCLES - 8'h01;

    // Conversion sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= adcc_pkg::ST_OFF;
            go_r      <= 1'b0;
            seg_cnt_r <= 8'h00;
            bit_idx_r <= 4'h0;
            sar_r     <= 10'h000;
        end else begin
            case (state_r)
                // Converter disabled
                adcc_pkg::ST_OFF: begin
                    go_r <= 1'b0;
                    if (on_r) begin
                        state_r <= adcc_pkg::ST_ACQ;
                    end
                end
                // Acquiring on selected channel
                adcc_pkg::ST_ACQ: begin
                    if (!on_r) begin
                        state_r <= adcc_pkg::ST_OFF;
                    end else if (go_start) begin
                        state_r   <= adcc_pkg::ST_SEG1;
                        go_r      <= 1'b1;
                        seg_cnt_r <= 8'h00;
                    end
                end
                // First segment: at least an instruction cycle
                adcc_pkg::ST_SEG1: begin
                    if (seg_cnt_r != 8'hFF) begin
                        seg_cnt_r <= seg_cnt_r + 8'h01;
                    end
                    if (abort) begin
                        state_r <= adcc_pkg::ST_ACQ;
                        go_r    <= 1'b0;
                    end else if (tad_tick && seg_cnt_r >= TCY_LAST) begin
                        state_r   <= adcc_pkg::ST_CONV;
                        bit_idx_r <= adcc_pkg::SAR_MSB;
                        sar_r     <= 10'h200;
                    end
                end
                // One bit decided per bit period
                default: begin
                    if (abort) begin
                        state_r <= adcc_pkg::ST_ACQ;
                        go_r    <= 1'b0;
                    end else if (tad_tick) begin
                        if (bit_idx_r == 4'h0) begin
                            sar_r   <= sar_eval;
                            state_r <= adcc_pkg::ST_ACQ;
                            go_r    <= 1'b0;
                        end else begin
                            sar_r     <= sar_eval | (bit_mask >> 1);
                            bit_idx_r <= bit_idx_r - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Justify the finished word, pad with zeros
    always_comb begin
        if (cfg_r[adcc_pkg::CFG_JUST_BIT]) begin
            new_hi = {adcc_pkg::PAD_ZERO, sar_eval[9:8]};
            new_lo = sar_eval[7:0];
        end else begin
            new_hi = sar_eval[9:2];
            new_lo = {sar_eval[1:0], adcc_pkg::PAD_ZERO};
        end
    end

    // Result pair: completion load wins over software write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            resh_r <= adcc_pkg::RES_RESET;
            resl_r <= adcc_pkg::RES_RESET;
        end else if (done) begin
            resh_r <= new_hi;
            resl_r <= new_lo;
        end else begin
            if (wr_resh) begin
                resh_r <= w_byte_r;
            end
            if (wr_resl) begin
                resl_r <= w_byte_r;
            end
        end
    end

    // Comparator from analog side: three stages, agree on two and three
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
            cmp_r    <= 1'b0;
        end else begin
            cmp_s1_r <= comp_above;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            if (cmp_s2_r == cmp_s3_r) begin
                cmp_r <= cmp_s3_r;
            end
        end
    end

    // Port configuration table: analog mask and reference sources
    always_comb begin
        map_vpos = 1'b0;
        map_vneg = 1'b0;
        case (cfg_r[adcc_pkg::CFG_PCFG_LSB +: 4])
            4'h0: map_analog = 8'hFF;
            4'h1: begin map_analog = 8'hFF; map_vpos = 1'b1; end
            4'h2: map_analog = 8'h1F;
            4'h3: begin map_analog = 8'h1F; map_vpos = 1'b1; end
            4'h4: map_analog = 8'h0B;
            4'h5: begin map_analog = 8'h0B; map_vpos = 1'b1; end
            4'h6: map_analog = 8'h00;
            4'h7: map_analog = 8'h00;
            4'h8: begin map_analog = 8'hFF; map_vpos = 1'b1; map_vneg = 1'b1; end
            4'h9: map_analog = 8'h3F;
            4'hA: begin map_analog = 8'h3F; map_vpos = 1'b1; end
            4'hB: begin map_analog = 8'h3F; map_vpos = 1'b1; map_vneg = 1'b1; end
            4'hC: begin map_analog = 8'h1F; map_vpos = 1'b1; map_vneg = 1'b1; end
            4'hD: begin map_analog = 8'h0F; map_vpos = 1'b1; map_vneg = 1'b1; end
            4'hE: map_analog = 8'h01;
            default: begin map_analog = 8'h0D; map_vpos = 1'b1; map_vneg = 1'b1; end
        endcase
    end

    // Pin and front end outputs, all analog from reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_analog_en <= adcc_pkg::PIN_RESET;
            vref_pos_ext  <= 1'b0;
            vref_neg_ext  <= 1'b0;
            chan_sel      <= 3'h0;
            sample_en     <= 1'b0;
            dac_code      <= 10'h000;
        end else begin
            pin_analog_en <= map_analog;
            vref_pos_ext  <= map_vpos;
            vref_neg_ext  <= map_vneg;
            chan_sel      <= chan_r;
            sample_en     <= (state_r == adcc_pkg::ST_ACQ) && on_r && !go_start;
            dac_code      <= sar_r;
        end
    end
endmodule

// File: adcc_pkg.sv
// Constants and types for the converter control block.
// Assumes a single 125 MHz system clock acts as the converter oscillator.
package adcc_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;              // System clock period
    localparam int TCY_OSC       = 4;              // Oscillator periods per instruction cycle
    localparam logic [7:0] TCY_CYCLES = 8'(TCY_OSC); // Instruction cycle in clocks
    localparam int RC_PERIOD_NS  = 4000;           // Internal RC bit period
    localparam int RC_CYCLES     = RC_PERIOD_NS / CLK_PERIOD_NS;

    // Bit period reloads (clocks per bit period)
    localparam logic [15:0] DIV_2   = 16'h0002;
    localparam logic [15:0] DIV_4   = 16'h0004;
    localparam logic [15:0] DIV_8   = 16'h0008;
    localparam logic [15:0] DIV_16  = 16'h0010;
    localparam logic [15:0] DIV_32  = 16'h0020;
    localparam logic [15:0] DIV_64  = 16'h0040;
    localparam logic [15:0] DIV_RC  = 16'(RC_CYCLES);

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CFG  = 10'h09F;     // converter_config
    localparam logic [9:0] IDX_CTRL = 10'h01F;     // converter_control_primary
    localparam logic [9:0] IDX_RESH = 10'h01E;     // result_high_byte
    localparam logic [9:0] IDX_RESL = 10'h09E;     // result_low_byte

    // Configuration register fields
    localparam int CFG_JUST_BIT = 7;               // result_justify_sel
    localparam int CFG_DIVH_BIT = 6;               // conv_clock_div_high
    localparam int CFG_PCFG_LSB = 0;               // port_analog_cfg
    localparam logic [7:0] CFG_WMASK = 8'hCF;      // Bits 5:4 unimplemented
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Control register fields
    localparam int CTRL_ON_BIT   = 0;              // Converter enable
    localparam int CTRL_GO_BIT   = 2;              // Go/done
    localparam int CTRL_CHAN_LSB = 3;              // Channel select, 3 bits
    localparam int CTRL_DIVL_LSB = 6;              // conv_clock_div_low, 2 bits

    // Result and pin defaults
    localparam logic [7:0] RES_RESET  = 8'h00;
    localparam logic [7:0] PIN_RESET  = 8'hFF;     // All pins analog
    localparam int         SAR_BITS   = 10;
    localparam logic [3:0] SAR_MSB    = 4'h9;
    localparam logic [5:0] PAD_ZERO   = 6'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_ACQ  = 2'b01,
        ST_SEG1 = 2'b10,
        ST_CONV = 2'b11
    } adcc_state_t;
endpackage

// File: adcc_tad_div.sv
// Bit period divider: one-cycle tick every selected number of clocks.
// Assumes the caller restarts it when a conversion is launched.
`timescale 1ns/1ns
module adcc_tad_div (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       restart,
    input  wire logic [2:0] sel,
    // Tick out
    output logic            tick
);
    logic [15:0] reload;   // Clocks per bit period
    logic [15:0] cnt_r;    // Down counter

    // Three-bit select to period
    always_comb begin
        case (sel)
            3'h0:    reload = adcc_pkg::DIV_2;
            3'h1:    reload = adcc_pkg::DIV_8;
            3'h2:    reload = adcc_pkg::DIV_32;
            3'h4:    reload = adcc_pkg::DIV_4;
            3'h5:    reload = adcc_pkg::DIV_16;
            3'h6:    reload = adcc_pkg::DIV_64;
            default: reload = adcc_pkg::DIV_RC;
        endcase
    end

    // Count down, tick on wrap
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (restart) begin
            // One clock shorter so the first segment ends within a period
            cnt_r <= reload - 16'h0002;
            tick  <= 1'b0;
        end else if (cnt_r == 16'h0000) begin
            cnt_r <= reload - 16'h0001;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule

// File: adcc_top_asserts.sv
// Checker for the converter control bus handshakes and pin reset state.
// Assumes it is bound into every adcc_top instance.
`timescale 1ns/1ns
module adcc_top_asserts (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins
    input wire logic [7:0]  pin_analog_en
);
    // Read index hits a register
    wire logic map_hit = s_axi_araddr[11:2] inside {adcc_pkg::IDX_CFG, adcc_pkg::IDX_CTRL,
                                                  adcc_pkg::IDX_RESH, adcc_pkg::IDX_RESL};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Both write channels taken together
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_pins_reset_analog: assert property (!$past(rstn) |-> pin_analog_en == 8'hFF)
        else $error("pins not analog after reset");
    a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_cfg_gap_zero: assert property (rd_take ##0 s_axi_araddr[11:2] == adcc_pkg::IDX_CFG
        |=> s_axi_rdata[5:4] == 2'h0) else $error("config bits 5:4 not zero");
    a_unmapped_read: assert property (rd_take ##0 !map_hit |=>
        s_axi_rresp == adcc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind adcc_top adcc_top_asserts adcc_top_asserts_inst (.*);

// File: adc_conversion_control_bench.sv
// Bench for adcc_top: config, pins, result storage, conversions, abort.
// Assumes a 125 MHz clock and an analog input half a step above ain.
`timescale 1ns/1ns
module adc_conversion_control_bench;
    logic        ref_clk, rstn, comp_above, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd_v;
    logic [3:0]  s_axi_wstrb;
    logic [9:0]  ain;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [9:0]  dac_code;
    wire logic [2:0]  chan_sel;
    wire logic [7:0]  pin_analog_en;
    wire logic   sample_en, vref_pos_ext, vref_neg_ext;
    int          error_cnt, checks;
    adcc_top adcc_top_inst (.*);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Comparator model
    always @(posedge ref_clk) comp_above <= (ain >= dac_code);
    // Watchdog
    initial begin
        #320000;
        error_cnt++;
        print_verdict;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge ref_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            begin @(posedge ref_clk iff s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin @(posedge ref_clk iff s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        repeat (2) @(posedge ref_clk);
        s_axi_bready <= 1'b1;
        @(posedge ref_clk iff s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [1:0] er = 2'h0);
        @(posedge ref_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        @(posedge ref_clk iff s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge ref_clk);
        s_axi_rready <= 1'b1;
        @(posedge ref_clk iff s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_v = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    // Port codes, reserved bits, unmapped place, reset in mid-run
    task automatic t_config;
        logic [3:0] code [5] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'hF};
        logic [9:0] pins [5] = '{10'h3FC, 10'h3FE, 10'h000, 10'h000, 10'h037};
        for (int i = 0; i < 5; i++) begin
            wr(adcc_pkg::IDX_CFG, {4'hF, code[i]});
            rd(adcc_pkg::IDX_CFG);
            chk(rd_v, {24'h0, 4'hC, code[i]});
            chk({pin_analog_en, vref_pos_ext, vref_neg_ext}, pins[i]);
        end
        wr(10'h000, 8'h11, adcc_pkg::RESP_SLVERR);
        rd(10'h000, adcc_pkg::RESP_SLVERR);
        chk(rd_v, 32'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(pin_analog_en, 8'hFF);
        rstn <= 1'b1;
        rd(adcc_pkg::IDX_CFG);
        chk(rd_v, 32'h0);
    endtask
    // Result bytes as plain storage while off; strobe-less write ignored
    task automatic t_store;
        wr(adcc_pkg::IDX_RESH, 8'hA5);
        wr(adcc_pkg::IDX_RESL, 8'h5A);
        s_axi_wstrb <= 4'h0;
        wr(adcc_pkg::IDX_RESH, 8'hFF);
        s_axi_wstrb <= 4'hF;
        rd(adcc_pkg::IDX_RESH);
        chk(rd_v, 32'hA5);
        rd(adcc_pkg::IDX_RESL);
        chk(rd_v, 32'h5A);
    endtask
    // One full conversion, timed and checked in the chosen format
    task automatic t_conv(input logic [7:0] cfg, ctl, input int n, input logic [9:0] v);
        time t0;
        ain <= v;
        wr(adcc_pkg::IDX_CFG, cfg);
        wr(adcc_pkg::IDX_CTRL, ctl);
        t0 = $time;
        wr(adcc_pkg::IDX_CTRL, ctl | 8'h04);
        rd(adcc_pkg::IDX_CTRL);
        chk(rd_v[2], 1'b1);
        do rd(adcc_pkg::IDX_CTRL); while (rd_v[2] !== 1'b0);
        t0 = ($time - t0) / 8;
        chk(t0 >= 10 * n && t0 <= 12 * n + 40, 1'b1);
        rd(adcc_pkg::IDX_RESH);
        chk(rd_v, cfg[7] ? {6'h0, v[9:8]} : v[9:2]);
        rd(adcc_pkg::IDX_RESL);
        chk(rd_v, cfg[7] ? v[7:0] : {v[1:0], 6'h0});
    endtask
    // Abort mid-conversion, then a fresh start
    task automatic t_abort;
        ain <= 10'h155;
        wr(adcc_pkg::IDX_CTRL, 8'hED);
        repeat (1500) @(posedge ref_clk);
        wr(adcc_pkg::IDX_CTRL, 8'hE9);
        rd(adcc_pkg::IDX_CTRL);
        chk(rd_v, 32'hE9);
        chk({sample_en, chan_sel}, 4'hD);
        repeat (6000) @(posedge ref_clk);
        rd(adcc_pkg::IDX_RESH);
        chk(rd_v, 32'hB5);
        rd(adcc_pkg::IDX_RESL);
        chk(rd_v, 32'h40);
        t_conv(8'hC0, 8'hA9, 64, 10'h155);
    endtask
    initial begin
        rstn = 1'b0;
        ain = 10'h2D5;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        repeat (16) @(posedge ref_clk);
        chk(pin_analog_en, 8'hFF);
        rstn <= 1'b1;
        t_config;
        t_store;
        t_conv(8'hC0, 8'hA9, 64, 10'h2D5);
        t_conv(8'h40, 8'h69, 16, 10'h0A3);
        t_conv(8'h00, 8'hE9, 500, 10'h2D5);
        t_abort;
        print_verdict;
    end
endmodule
